// ===== common/csic_pkg.sv
/*
  Shared constants of the clock, standby and interrupt control block:
  divide-select codes, control bit positions, flag positions, reset
  values and cycle counts.
  Assumes one 125 MHz main clock and a synchronous active-high reset.
*/
`default_nettype none

package csic_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  localparam int DIV_SWITCH_MAX_CYC = 64;   // latest switch, main clocks
  localparam int HALT_EXIT_MAX_MS = 500;    // longest halt via timebase
  // longest time in main clock cycles, an exact product
  localparam longint HALT_EXIT_MAX_CYC = longint'(HALT_EXIT_MAX_MS) * 1000 * CLK_MHZ;
  localparam int TB_PRESCALE_BITS = 7;      // oscillator / 128
  localparam int TB_DIV_BITS = 14;          // frequency divider
  localparam int TB_WIDTH = TB_PRESCALE_BITS + TB_DIV_BITS;
  localparam int DIV_CNT_W = 5;             // longest ratio is 32

  // ****************************************************************
  // divide-select codes
  // ****************************************************************
  localparam logic [1:0] DIV_SEL_32 = 2'h0;
  localparam logic [1:0] DIV_SEL_1 = 2'h1;
  localparam logic [1:0] DIV_SEL_2 = 2'h2;
  localparam logic [1:0] DIV_SEL_RSVD = 2'h3;

  // ****************************************************************
  // control register bit positions (operand 0000 to 1000)
  // ****************************************************************
  localparam int CTL_BITS = 9;
  localparam logic [3:0] CTL_OPND_MAX = 4'h8;
  localparam int CTL_DIV_LO = 0;
  localparam int CTL_DIV_HI = 1;
  localparam int CTL_DEEP_SLEEP = 2;
  localparam int CTL_HOLD_START_WAKE = 3;
  localparam int CTL_HALT_START_WAKE = 4;
  localparam int CTL_MASTER_IE = 5;
  localparam int CTL_HALT_INT_WAKE = 6;
  localparam logic [CTL_BITS-1:0] CTL_RST = 9'h000;

  // ****************************************************************
  // interrupt sources and flag positions
  // ****************************************************************
  localparam int IRQ_NUM = 5;
  localparam int IRQ_EXT0 = 0;
  localparam int IRQ_EXT1 = 1;
  localparam int IRQ_TIMEBASE = 2;
  localparam int IRQ_TIMER1 = 3;
  localparam int IRQ_SERIAL = 4;
  localparam logic [IRQ_NUM-1:0] IRQ_EN_RST = 5'h00;
  localparam logic IRQ_TIMER1_RST = 1'b1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {IO_NONE, IO_READ, IO_WRITE} csic_io_type;
  typedef enum logic [1:0] {ST_RUN, ST_HOLD_NOP, ST_HOLD, ST_HALT} csic_state_type;

endpackage

`default_nettype wire

// ===== rtl/csic_clk_div.sv
/*
  System clock divider: produces a one-cycle system tick at 1/1, 1/2
  or 1/32 of the main clock.
  Assumes div_sel_in comes from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module csic_clk_div (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic [1:0] div_sel_in,
  input wire logic run_in,
  // status
  output logic tick_out,
  output logic [1:0] ratio_out
);

  logic [csic_pkg::DIV_CNT_W-1:0] cnt_r;
  logic [1:0] ratio_r;
  logic boundary;
  logic tick_nxt;

  // all ratios tick together at the counter wrap, so a switch there
  // never shortens a system clock period
  assign boundary = (cnt_r == {csic_pkg::DIV_CNT_W{1'b1}});

  // ****************************************************************
  // free-running divide counter
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // new ratio taken only at the wrap, within 32 main clocks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ratio_r <= csic_pkg::DIV_SEL_32;
    end else if (boundary && div_sel_in != csic_pkg::DIV_SEL_RSVD) begin
      ratio_r <= div_sel_in;
    end
  end

  // tick decode per ratio
  always_comb begin
    unique case (ratio_r)
      csic_pkg::DIV_SEL_1: tick_nxt = 1'b1;
      csic_pkg::DIV_SEL_2: tick_nxt = cnt_r[0];
      default: tick_nxt = boundary;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_nxt & run_in;
    end
  end

  assign ratio_out = ratio_r;

endmodule

`default_nettype wire

// ===== rtl/csic_top.sv
/*
  Clock, standby and interrupt control of a small microcontroller:
  system clock divide select, halt and hold standby with wake sources,
  timebase watchdog, interrupt enables and the pseudo-port request flags.
  Assumes instruction strobes are one-cycle pulses from the core on the
  same clock; the wake pin arrives asynchronously.
*/
// What this block does
// - system clock is main clock over 32, 1 or 2; code 3 is reserved.
// - divide select resets to over-32 unless the power-on over-1 option is set.
// - new divide setting takes effect within 64 main clocks of the write.
// - with the power-on over-1 option, divide setting writes are ignored.
// - halt ends when the wake pin is high and halt pin-wake is enabled.
// - halt ends on interrupt release when halt interrupt-wake is enabled.
// - timebase 14-bit divider overflow ends halt, within half a second.
// - halt with deep sleep selected enters hold instead.
// - one no-operation instruction cycle runs before hold is entered.
// - hold ends only on reset or wake pin high with hold pin-wake enabled.
// - overflow with timebase flag already set gives watchdog reset, ends halt.
// - watchdog reset exists only when the build option selects it.
// - control bit 5 is master enable; five enables, one bit each, reset zero.
// - entering hold clears all interrupt enables, and all request flags not set by a hardware event in that cycle.
// - bank after port read clears selected flags; after port write sets them.
// - reset clears every request flag except the timer 1 flag.
// - serial flag clears when a serial transfer starts.
// - port bit set or clear after bank leaves request flags alone.
// - control bit set and clear address one bit, operand 0 to 8.
`timescale 1ns/100ps
`default_nettype none

module csic_top #(
  parameter bit POWER_ON_DIV1 = 1'b0,
  parameter bit WATCHDOG_EN = 1'b1,
  parameter int TB_WIDTH = csic_pkg::TB_WIDTH
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control bit instructions
  input wire logic set_control_bit_op_in,
  input wire logic clear_control_bit_op_in,
  input wire logic [3:0] ctl_operand_in,
  // interrupt enable instructions
  input wire logic set_irq_enable_op_in,
  input wire logic clear_irq_enable_op_in,
  input wire logic [2:0] irq_enable_index_in,
  // pseudo-port instructions
  input wire logic port_read_op_in,
  input wire logic port_write_op_in,
  input wire logic bank_op_in,
  input wire logic port_bit_set_op_in,
  input wire logic port_bit_clear_op_in,
  input wire logic [csic_pkg::IRQ_NUM-1:0] acc_select_in,
  // standby and events
  input wire logic halt_op_in,
  input wire logic wake_start_pin_in,
  input wire logic int_release_in,
  input wire logic [csic_pkg::IRQ_NUM-1:0] irq_event_in,
  input wire logic serial_start_in,
  // system clock
  output logic sys_tick_out,
  output logic [1:0] active_ratio_out,
  // control and status
  output logic [csic_pkg::CTL_BITS-1:0] control_out,
  output logic [csic_pkg::IRQ_NUM-1:0] irq_enable_out,
  output logic [csic_pkg::IRQ_NUM-1:0] irq_flags_out,
  output logic halted_out,
  output logic holding_out,
  output logic watchdog_reset_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [csic_pkg::CTL_BITS-1:0] ctl_r;
  logic [csic_pkg::IRQ_NUM-1:0] ien_r;
  logic [csic_pkg::IRQ_NUM-1:0] iflag_r;
  logic [csic_pkg::IRQ_NUM-1:0] iflag_nxt;
  logic [TB_WIDTH-1:0] tb_cnt_r;
  logic pin_meta_r;
  logic pin_sync_r;
  logic wdt_r;
  logic halted_r;
  logic holding_r;
  csic_pkg::csic_io_type last_io_r;
  csic_pkg::csic_state_type state_r;
  logic tb_ovf;
  logic wdt_fire;
  logic hold_enter;
  logic halt_wake;
  logic sys_tick;
  logic [1:0] ratio;
  logic ctl_ok;

  // ****************************************************************
  // system clock divider
  // ****************************************************************
  csic_clk_div u_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .div_sel_in(ctl_r[csic_pkg::CTL_DIV_HI:csic_pkg::CTL_DIV_LO]),
    .run_in(state_r == csic_pkg::ST_RUN || state_r == csic_pkg::ST_HOLD_NOP),
    .tick_out(sys_tick),
    .ratio_out(ratio)
  );

  // ****************************************************************
  // wake pin synchroniser
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= wake_start_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  assign ctl_ok = (ctl_operand_in <= csic_pkg::CTL_OPND_MAX);

  // hold entry wipes the master enable along with the source enables
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctl_r <= csic_pkg::CTL_RST;
      ctl_r[csic_pkg::CTL_DIV_LO] <= POWER_ON_DIV1;
    end else if (hold_enter) begin
      ctl_r[csic_pkg::CTL_MASTER_IE] <= 1'b0;
    end else if (ctl_ok && (set_control_bit_op_in || clear_control_bit_op_in)) begin
      // one bit per instruction; locked divide ignores writes
      if (!(POWER_ON_DIV1 && ctl_operand_in <= 4'(csic_pkg::CTL_DIV_HI))) begin
        ctl_r[ctl_operand_in] <= set_control_bit_op_in;
      end
    end
  end

  // ****************************************************************
  // interrupt enable flags
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ien_r <= csic_pkg::IRQ_EN_RST;
    end else if (hold_enter) begin
      ien_r <= '0;
    end else if (irq_enable_index_in < 3'(csic_pkg::IRQ_NUM)) begin
      if (set_irq_enable_op_in) begin
        ien_r[irq_enable_index_in] <= 1'b1;
      end else if (clear_irq_enable_op_in) begin
        ien_r[irq_enable_index_in] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // pseudo-port sequencing
  // ****************************************************************
  // remembers whether the last port op was a read or a write; a bank
  // consumes it, so a following port bit op never reaches the flags
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_io_r <= csic_pkg::IO_NONE;
    end else if (port_read_op_in) begin
      last_io_r <= csic_pkg::IO_READ;
    end else if (port_write_op_in) begin
      last_io_r <= csic_pkg::IO_WRITE;
    end else if (bank_op_in || port_bit_set_op_in || port_bit_clear_op_in) begin
      last_io_r <= csic_pkg::IO_NONE;
    end
  end

  // ****************************************************************
  // interrupt request flags
  // ****************************************************************
  // per-flag next value; hardware events win over any clear
  always_comb begin
    iflag_nxt = iflag_r;
    for (int i = 0; i < csic_pkg::IRQ_NUM; i++) begin
      if (bank_op_in && last_io_r == csic_pkg::IO_READ && acc_select_in[i]) begin
        iflag_nxt[i] = 1'b0;
      end
      if (bank_op_in && last_io_r == csic_pkg::IO_WRITE && acc_select_in[i]) begin
        iflag_nxt[i] = 1'b1;
      end
      if (hold_enter) begin
        iflag_nxt[i] = 1'b0;
      end
      if (i == csic_pkg::IRQ_SERIAL && serial_start_in) begin
        iflag_nxt[i] = 1'b0;
      end
      if (irq_event_in[i]) begin
        iflag_nxt[i] = 1'b1;
      end
    end
    if (tb_ovf) begin
      iflag_nxt[csic_pkg::IRQ_TIMEBASE] = 1'b1;
    end
  end

  // timer 1 flag comes up set, as reset loads it with IRQ_TIMER1_RST
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      iflag_r <= '0;
      iflag_r[csic_pkg::IRQ_TIMER1] <= csic_pkg::IRQ_TIMER1_RST;
    end else begin
      iflag_r <= iflag_nxt;
    end
  end

  // ****************************************************************
  // timebase and watchdog
  // ****************************************************************
  // prescale 1/128 then 14-bit divider; the oscillator stops in hold
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tb_cnt_r <= '0;
    end else if (state_r != csic_pkg::ST_HOLD) begin
      tb_cnt_r <= tb_cnt_r + 1'b1;
    end
  end

  assign tb_ovf = (state_r != csic_pkg::ST_HOLD) && (&tb_cnt_r);
  // second overflow with the flag still pending means a runaway
  assign wdt_fire = WATCHDOG_EN && tb_ovf && iflag_r[csic_pkg::IRQ_TIMEBASE];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wdt_r <= 1'b0;
    end else begin
      wdt_r <= wdt_fire;
    end
  end

  // ****************************************************************
  // standby state machine
  // ****************************************************************
  assign halt_wake = (pin_sync_r && ctl_r[csic_pkg::CTL_HALT_START_WAKE])
    || (int_release_in && ctl_r[csic_pkg::CTL_HALT_INT_WAKE])
    || tb_ovf || wdt_fire;
  assign hold_enter = (state_r == csic_pkg::ST_HOLD_NOP) && sys_tick;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= csic_pkg::ST_RUN;
    end else begin
      unique case (state_r)
        csic_pkg::ST_RUN: begin
          if (halt_op_in) begin
            if (ctl_r[csic_pkg::CTL_DEEP_SLEEP]) begin
              state_r <= csic_pkg::ST_HOLD_NOP;
            end else if (!halt_wake) begin
              state_r <= csic_pkg::ST_HALT;
            end
          end
        end
        csic_pkg::ST_HOLD_NOP: begin
          // one more instruction cycle runs as a no-op
          if (sys_tick) begin
            state_r <= csic_pkg::ST_HOLD;
          end
        end
        csic_pkg::ST_HOLD: begin
          // no timebase, no interrupt: only the pin can wake it
          if (pin_sync_r && ctl_r[csic_pkg::CTL_HOLD_START_WAKE]) begin
            state_r <= csic_pkg::ST_RUN;
          end
        end
        csic_pkg::ST_HALT: begin
          if (halt_wake) begin
            state_r <= csic_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // registered status outputs
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      halted_r <= 1'b0;
      holding_r <= 1'b0;
    end else begin
      halted_r <= (state_r == csic_pkg::ST_HALT);
      holding_r <= (state_r == csic_pkg::ST_HOLD);
    end
  end

  assign sys_tick_out = sys_tick;
  assign active_ratio_out = ratio;
  assign control_out = ctl_r;
  assign irq_enable_out = ien_r;
  assign irq_flags_out = iflag_r;
  assign halted_out = halted_r;
  assign holding_out = holding_r;
  assign watchdog_reset_out = wdt_r;

endmodule

`default_nettype wire

// ===== sim/csic_top_asserts.sv
/*
  Checker of the clock, standby and interrupt control block: assertions
  on the top module's ports, bound to every instance of it.
  Assumes the bench never issues control writes during hold entry.
*/
`timescale 1ns/100ps
`default_nettype none

module csic_top_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // instructions and events
  input wire logic set_control_bit_op_in,
  input wire logic clear_control_bit_op_in,
  input wire logic [3:0] ctl_operand_in,
  input wire logic set_irq_enable_op_in,
  input wire logic [2:0] irq_enable_index_in,
  input wire logic wake_start_pin_in,
  input wire logic int_release_in,
  input wire logic [csic_pkg::IRQ_NUM-1:0] irq_event_in,
  input wire logic serial_start_in,
  // outputs watched
  input wire logic sys_tick_out,
  input wire logic [1:0] active_ratio_out,
  input wire logic [csic_pkg::CTL_BITS-1:0] control_out,
  input wire logic [csic_pkg::IRQ_NUM-1:0] irq_enable_out,
  input wire logic [csic_pkg::IRQ_NUM-1:0] irq_flags_out,
  input wire logic halted_out,
  input wire logic holding_out,
  input wire logic watchdog_reset_out
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // divide bits left out: the power-on option may lock them
  property p_ctl_set;
    set_control_bit_op_in && ctl_operand_in >= 4'h2 && ctl_operand_in <= 4'h8
      |=> control_out[$past(ctl_operand_in)];
  endproperty
  a_ctl_set: assert property (p_ctl_set) else $error("control bit not set");

  property p_ctl_clr;
    clear_control_bit_op_in && !set_control_bit_op_in && ctl_operand_in >= 4'h2
      && ctl_operand_in <= 4'h8 |=> !control_out[$past(ctl_operand_in)];
  endproperty
  a_ctl_clr: assert property (p_ctl_clr) else $error("control bit not cleared");

  property p_ctl_ign;
    (set_control_bit_op_in || clear_control_bit_op_in) && ctl_operand_in > 4'h8
      |=> $stable(control_out);
  endproperty
  a_ctl_ign: assert property (p_ctl_ign) else $error("operand above 8 took effect");

  property p_ien_set;
    set_irq_enable_op_in && irq_enable_index_in < 3'h5
      |=> irq_enable_out[$past(irq_enable_index_in)];
  endproperty
  a_ien_set: assert property (p_ien_set) else $error("enable not set");

  property p_ratio_ok;
    active_ratio_out != 2'h3;
  endproperty
  a_ratio_ok: assert property (p_ratio_ok) else $error("reserved ratio in use");

  property p_ratio_lag;
    $changed(control_out[1:0]) |-> ##[0:64]
      (active_ratio_out == control_out[1:0] || control_out[1:0] == 2'h3);
  endproperty
  a_ratio_lag: assert property (p_ratio_lag) else $error("ratio switch too late");

  property p_tick_half;
    sys_tick_out && active_ratio_out == 2'h2 |=> !sys_tick_out || active_ratio_out != 2'h2;
  endproperty
  a_tick_half: assert property (p_tick_half) else $error("short tick at half rate");

  property p_hold_clr;
    $rose(holding_out) |-> irq_enable_out == 5'h00 && !control_out[5];
  endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("enables kept in hold");

  // three samples back cover the pin synchroniser lag
  property p_hold_stay;
    holding_out && !wake_start_pin_in && !$past(wake_start_pin_in)
      && !$past(wake_start_pin_in, 2) && !$past(wake_start_pin_in, 3) |=> holding_out;
  endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("hold left without pin");

  property p_halt_int;
    halted_out && int_release_in && control_out[6] |-> ##[1:4] !halted_out;
  endproperty
  a_halt_int: assert property (p_halt_int) else $error("halt kept on release");

  property p_wdog;
    watchdog_reset_out |-> $past(irq_flags_out[2]) ##1 !watchdog_reset_out;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog pulse bad");

  property p_serial;
    serial_start_in && !irq_event_in[4] |=> !irq_flags_out[4];
  endproperty
  a_serial: assert property (p_serial) else $error("serial flag kept");

  c_halt: cover property ($rose(halted_out));
  c_hold: cover property ($rose(holding_out));
  c_wdog: cover property (watchdog_reset_out);
endmodule

bind csic_top csic_top_asserts u_asserts (
  .clk_in(clk_in), .rst_in(rst_in),
  .set_control_bit_op_in(set_control_bit_op_in),
  .clear_control_bit_op_in(clear_control_bit_op_in),
  .ctl_operand_in(ctl_operand_in), .set_irq_enable_op_in(set_irq_enable_op_in),
  .irq_enable_index_in(irq_enable_index_in), .wake_start_pin_in(wake_start_pin_in),
  .int_release_in(int_release_in), .irq_event_in(irq_event_in),
  .serial_start_in(serial_start_in), .sys_tick_out(sys_tick_out),
  .active_ratio_out(active_ratio_out), .control_out(control_out),
  .irq_enable_out(irq_enable_out), .irq_flags_out(irq_flags_out),
  .halted_out(halted_out), .holding_out(holding_out),
  .watchdog_reset_out(watchdog_reset_out)
);

`default_nettype wire

// ===== sim/tb.sv
/*
  Self-checking bench of the clock, standby and interrupt control block.
  Assumes a six-bit timebase so overflows come every 64 clocks.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  // ********
  // signals and models
  // ********
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs = 1'b0, cc = 1'b0, es = 1'b0, ec = 1'b0, rd = 1'b0, wr = 1'b0;
  logic bk = 1'b0, ps = 1'b0, pc = 1'b0, hl = 1'b0, pin = 1'b0, rel = 1'b0, ser = 1'b0;
  logic [3:0] opnd = 4'h0;
  logic [4:0] acc = 5'h00, ev = 5'h00;
  logic tick, halted, holding, wdog;
  logic [1:0] ratio;
  logic [8:0] ctl, ctl_m;
  logic [4:0] ien, flg, ien_m, flg_m;
  logic [8:0] ctl1;
  logic [1:0] ratio1;
  logic wdog1;
  int pend = 0;
  int num_errors = 0;
  int checks = 0;

  csic_top #(.TB_WIDTH(6)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .set_control_bit_op_in(cs),
    .clear_control_bit_op_in(cc), .ctl_operand_in(opnd), .set_irq_enable_op_in(es),
    .clear_irq_enable_op_in(ec), .irq_enable_index_in(opnd[2:0]), .port_read_op_in(rd),
    .port_write_op_in(wr), .bank_op_in(bk), .port_bit_set_op_in(ps),
    .port_bit_clear_op_in(pc), .acc_select_in(acc), .halt_op_in(hl),
    .wake_start_pin_in(pin), .int_release_in(rel), .irq_event_in(ev),
    .serial_start_in(ser), .sys_tick_out(tick), .active_ratio_out(ratio),
    .control_out(ctl), .irq_enable_out(ien), .irq_flags_out(flg),
    .halted_out(halted), .holding_out(holding), .watchdog_reset_out(wdog)
  );

  // build options flipped: divide locked at over-1 and no watchdog
  csic_top #(.TB_WIDTH(6), .POWER_ON_DIV1(1'b1), .WATCHDOG_EN(1'b0)) DUT_OPT (
    .clk_in(clk_in), .rst_in(rst_in), .set_control_bit_op_in(cs),
    .clear_control_bit_op_in(cc), .ctl_operand_in(opnd), .set_irq_enable_op_in(es),
    .clear_irq_enable_op_in(ec), .irq_enable_index_in(opnd[2:0]), .port_read_op_in(rd),
    .port_write_op_in(wr), .bank_op_in(bk), .port_bit_set_op_in(ps),
    .port_bit_clear_op_in(pc), .acc_select_in(acc), .halt_op_in(hl),
    .wake_start_pin_in(pin), .int_release_in(rel), .irq_event_in(ev),
    .serial_start_in(ser), .sys_tick_out(), .active_ratio_out(ratio1),
    .control_out(ctl1), .irq_enable_out(), .irq_flags_out(),
    .halted_out(), .holding_out(), .watchdog_reset_out(wdog1)
  );

  always #4 clk_in = ~clk_in;

  // ********
  // tasks
  // ********
  task automatic chk(input logic [8:0] s, input logic [8:0] e, input string n);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %0h seen %0h", n, e, s);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one instruction pulse; k picks it, the models follow
  task automatic op(input int k, input logic [3:0] n, input logic [4:0] a);
    @(negedge clk_in);
    opnd = n;
    acc = a;
    case (k)
      0: cs = 1'b1;
      1: cc = 1'b1;
      2: es = 1'b1;
      3: ec = 1'b1;
      4: rd = 1'b1;
      5: wr = 1'b1;
      6: bk = 1'b1;
      7: ps = 1'b1;
      8: pc = 1'b1;
      9: hl = 1'b1;
      10: ev = a;
      default: ser = 1'b1;
    endcase
    @(negedge clk_in);
    {cs, cc, es, ec, rd, wr, bk, ps, pc, hl, ser} = 11'h000;
    ev = 5'h00;
    if (k < 2 && n <= 4'h8) ctl_m[n] = (k == 0);
    if ((k == 2 || k == 3) && n[2:0] < 3'h5) ien_m[n[2:0]] = (k == 2);
    if (k == 6 && pend != 0) flg_m = (pend == 2) ? (flg_m | a) : (flg_m & ~a);
    if (k >= 6 && k <= 8) pend = 0;
    if (k == 4 || k == 5) pend = k - 3;
    if (k == 10) flg_m = flg_m | a;
    if (k == 11) flg_m[4] = 1'b0;
  endtask

  // clear the timebase flag just after an overflow, leaving ~60 clocks
  task automatic tb_sync();
    int i;
    op(4, 4'h0, 5'h04);
    op(6, 4'h0, 5'h04);
    for (i = 0; i < 80 && flg[2] !== 1'b1; i++) @(negedge clk_in);
    op(4, 4'h0, 5'h04);
    op(6, 4'h0, 5'h04);
  endtask

  function automatic int gap(input logic [1:0] r);
    return (r == 2'h0) ? 32 : int'(r);
  endfunction

  // ********
  // watchdog and main sequence
  // ********
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    print_verdict();
  end

  initial begin
    int i, n, k;
    logic [1:0] c, r;
    void'($urandom(32'h8cf6));
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    ctl_m = 9'h000;
    ien_m = 5'h00;
    flg_m = 5'h08;
    chk(ctl, 9'h000, "control reset");
    chk(ctl1, 9'h001, "locked control reset");
    chk(9'(ien), 9'h000, "enable reset");
    chk(9'(flg), 9'h008, "flag reset");
    // random instructions; bit 2 masked as the timebase sets it freely
    for (i = 0; i < 80; i++) begin
      k = $urandom_range(0, 10);
      if (k == 9) k = 11;
      op(k, 4'($urandom), 5'($urandom));
      if (k == 4 || k == 5) begin
        op(6, 4'h0, 5'($urandom));
        op($urandom_range(7, 8), 4'h0, 5'h00);
        op(6, 4'h0, 5'h1F);
      end
      op(4, 4'h0, 5'h04);
      op(6, 4'h0, 5'h04);
      chk(ctl, ctl_m, "control");
      chk(ctl1, {ctl_m[8:2], 2'h1}, "locked control");
      chk(9'(ien), 9'(ien_m), "enables");
      chk(9'(flg & 5'h1B), 9'(flg_m & 5'h1B), "flags");
    end
    for (i = 0; i < 9; i++) op(1, 4'(i), 5'h00);
    // ratio walk 1, 2, reserved, 32
    for (i = 0; i < 4; i++) begin
      c = (i == 3) ? 2'h0 : 2'(i + 1);
      op(int'(!c[0]), 4'h0, 5'h00);
      op(int'(!c[1]), 4'h1, 5'h00);
      repeat (64) @(negedge clk_in);
      r = (c == 2'h3) ? 2'h2 : c;
      chk(9'(ratio), 9'(r), "ratio");
      chk(9'(ratio1), 9'h001, "locked ratio");
      for (n = 0; n < 40 && tick !== 1'b1; n++) @(negedge clk_in);
      n = 0;
      do begin
        @(negedge clk_in);
        n++;
      end while (tick !== 1'b1 && n < 40);
      chk(9'(n), 9'(gap(r)), "tick gap");
    end
    // halt left by release, by pin, by timebase
    for (i = 0; i < 3; i++) begin
      op(int'(i != 0), 4'h6, 5'h00);
      op(int'(i != 1), 4'h4, 5'h00);
      tb_sync();
      op(9, 4'h0, 5'h00);
      @(negedge clk_in);
      chk(9'(halted), 9'h001, "halt entry");
      rel = (i == 0);
      pin = (i == 1);
      for (n = 0; n < 72 && halted !== 1'b0; n++) @(negedge clk_in);
      chk(9'(halted), 9'h000, "halt exit");
      chk(9'((i == 2) == (n > 40)), 9'h001, "exit time");
      rel = 1'b0;
      pin = 1'b0;
      repeat (4) @(negedge clk_in);
    end
    // hold clears enables and flags and ignores release
    op(0, 4'h2, 5'h00);
    op(0, 4'h3, 5'h00);
    op(0, 4'h5, 5'h00);
    op(2, 4'h1, 5'h00);
    op(10, 4'h0, 5'h01);
    tb_sync();
    op(9, 4'h0, 5'h00);
    chk(9'(holding), 9'h000, "hold nop");
    for (n = 0; n < 40 && holding !== 1'b1; n++) @(negedge clk_in);
    chk(9'(holding), 9'h001, "hold entry");
    chk(9'({ien, ctl[5]}), 9'h000, "hold enables");
    chk(9'(flg), 9'h000, "hold flags");
    rel = 1'b1;
    repeat (100) @(negedge clk_in);
    chk(9'(holding), 9'h001, "hold kept");
    rel = 1'b0;
    pin = 1'b1;
    for (n = 0; n < 8 && holding !== 1'b0; n++) @(negedge clk_in);
    chk(9'(holding), 9'h000, "hold exit");
    pin = 1'b0;
    op(1, 4'h2, 5'h00);
    // flag left set across a second overflow
    tb_sync();
    for (n = 0; n < 70 && flg[2] !== 1'b1; n++) @(negedge clk_in);
    for (n = 0; n < 70 && wdog !== 1'b1; n++) @(negedge clk_in);
    chk(9'(wdog), 9'h001, "watchdog");
    chk(9'(wdog1), 9'h000, "watchdog off");
    print_verdict();
  end
endmodule

`default_nettype wire
